// ### pkg/bmme_defs.vh
// Purpose: Constants for the byte-mode memory reference execution block.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only; no logic lives here.
`ifndef BMME_DEFS_VH
`define BMME_DEFS_VH

// Instruction field positions.
`define BMME_OPC_HI        15
`define BMME_OPC_LO        11
`define BMME_MODE_HI       10
`define BMME_MODE_LO       9
`define BMME_IND_BIT       8
`define BMME_DISP_HI       7
`define BMME_DISP_LO       0

// High opcode bits of the executed instructions.
`define BMME_OPC_ADD       5'h11
`define BMME_OPC_SUB       5'h12
`define BMME_OPC_LDA       5'h16
`define BMME_OPC_LDX       5'h1C

// Mode field codes.
`define BMME_M_SCRATCH     2'h0
`define BMME_M_REL_FWD     2'h1
`define BMME_M_INDEXED     2'h2
`define BMME_M_REL_ALT     2'h3

// Reset values.
`define BMME_RST_WORD      16'h0000
`define BMME_RST_CYC       2'h0

// Execution time in clock cycles.
`define BMME_CYC_DIRECT    2'h2
`define BMME_CYC_INDIRECT  2'h3

`endif

// ### src/bmme_exec.v
// Purpose: Executes byte-mode add, subtract, load accumulator and load
//          index memory reference instructions, with word-mode fallback.
// Assumes: Memory answers a read in the same cycle MEM_RD_O is high;
//          all inputs come from logic on CLK_SYS_I.
// Notes:   One instruction at a time; START_I is ignored while busy.
//          Word mode runs the same four opcodes on full-word operands.
//          Other opcodes finish at once with a refusal pulse, no memory read.
//          The overflow flag itself lives outside; only a set pulse leaves here.
//
// Functional notes
// - Byte-mode indicator picks byte or word operands.
// - Byte operand zero-extended into operand word.
// - Bit 7 carry never sets overflow.
// - Relative forward forms word address, mode selects byte.
// - Direct indexed sums displacement and index.
// - Indirect bit fetches address pointer from memory.
// - Exactly one pointer level, never chained.
// - Indirect mode field decoded as word indirect.
// - Pointer location word address; content byte address.
// - Mode 00 indirect: pointer at scratchpad displacement.
// - Mode 01 indirect: pointer at P plus one plus D.
// - Mode 11 indirect: pointer at P minus D.
// - Indirect indexed: pointer content plus index register.
// - Add byte sums operand into accumulator.
// - Addition is full 16-bit, overflow flagged.
// - Subtract byte from accumulator, store difference.
// - Subtraction overflow sets overflow flag.
// - Load accumulator byte, upper half cleared.
// - Load index byte, upper half cleared.
// - Mode 11 selects byte 1, mode 01 byte 0.
// - Two cycles, one more when indirect.
`timescale 1ns/100ps
`include "bmme_defs.vh"

module bmme_exec (
    input  wire        CLK_SYS_I,
    input  wire        RST_I,
    // Request and the register context captured with it.
    input  wire        START_I,
    input  wire [15:0] INSTR_I,
    input  wire        BYTE_MODE_I,
    input  wire [15:0] PROG_CNT_I,
    input  wire [15:0] ACCUM_I,
    input  wire [15:0] INDEX_I,
    // Word memory read path.
    input  wire [15:0] MEM_RDATA_I,
    // Progress, memory request and write-back results.
    output reg         BUSY_O,
    output reg         DONE_O,
    output reg         BAD_OPCODE_O,
    output reg         MEM_RD_O,
    output reg  [15:0] MEM_ADDR_O,
    output reg  [15:0] ACCUM_O,
    output reg         ACCUM_WE_O,
    output reg  [15:0] INDEX_O,
    output reg         INDEX_WE_O,
    output reg         OVERFLOW_FLAG_SET_O,
    output reg  [1:0]  EXEC_CYCLES_O
);

    // One-hot execution states.
    localparam [3:0] S_IDLE   = 4'h1;
    localparam [3:0] S_DECODE = 4'h2;
    localparam [3:0] S_PTR    = 4'h4;
    localparam [3:0] S_OPND   = 4'h8;

    // Captured instruction, register context and cycle count.
    reg  [3:0]  state;
    reg  [15:0] instr;
    reg  [15:0] prog_cnt;
    reg  [15:0] accum;
    reg  [15:0] index;
    reg         byte_mode;
    reg         byte_sel;
    reg  [1:0]  cycles;

    // Decoded instruction fields.
    wire [4:0]  opc      = instr[`BMME_OPC_HI:`BMME_OPC_LO];
    wire [1:0]  mode     = instr[`BMME_MODE_HI:`BMME_MODE_LO];
    wire        indirect = instr[`BMME_IND_BIT];
    wire [15:0] disp     = {8'h00, instr[`BMME_DISP_HI:`BMME_DISP_LO]};
    // Opcode of the word waiting at the inputs.
    wire [4:0]  start_opc = INSTR_I[`BMME_OPC_HI:`BMME_OPC_LO];

    // Opcode is one of the four executed here.
    wire start_ok = (start_opc == `BMME_OPC_ADD) || (start_opc == `BMME_OPC_SUB) ||
                    (start_opc == `BMME_OPC_LDA) || (start_opc == `BMME_OPC_LDX);

    // Address arithmetic, all 16 bits wide so carries out drop.
    wire [15:0] rel_fwd  = prog_cnt + 16'h0001 + disp;
    wire [15:0] rel_back = prog_cnt - disp;
    wire [15:0] disp_idx = disp + index;
    wire [15:0] ptr_idx  = MEM_RDATA_I + index;

    // First read address and byte select, settled before the decode edge.
    reg  [15:0] next_addr;
    reg         next_sel;

    // First address: pointer location when indirect, else operand address.
    always @* begin
        next_addr = disp;
        next_sel  = 1'b0;
        if (indirect) begin
            // Pointer location is always a word address.
            case (mode)
                `BMME_M_SCRATCH: next_addr = disp;
                `BMME_M_REL_FWD: next_addr = rel_fwd;
                `BMME_M_INDEXED: next_addr = disp;
                `BMME_M_REL_ALT: next_addr = rel_back;
                default:         next_addr = disp;
            endcase
        end else if (byte_mode) begin
            // Byte-mode direct forms.
            case (mode)
                `BMME_M_SCRATCH: begin
                    // Byte address D: the word is D halved, bit 0 picks the byte.
                    next_addr = {1'b0, disp[15:1]};
                    next_sel  = disp[0];
                end
                `BMME_M_INDEXED: begin
                    // Byte address D plus X, halved, reaches only the words below 8000h.
                    next_addr = {1'b0, disp_idx[15:1]};
                    next_sel  = disp_idx[0];
                end
                default: begin
                    // Both relative codes go forward; mode bit 1 picks the byte.
                    next_addr = rel_fwd;
                    next_sel  = mode[1];
                end
            endcase
        end else begin
            // Word-mode direct forms.
            case (mode)
                `BMME_M_SCRATCH: next_addr = disp;
                `BMME_M_REL_FWD: next_addr = rel_fwd;
                `BMME_M_INDEXED: next_addr = disp_idx;
                `BMME_M_REL_ALT: next_addr = rel_back;
                default:         next_addr = disp;
            endcase
        end
    end

    // Operand address taken from the pointer word: a byte address in byte mode, a word address in word mode.
    reg  [15:0] eff;

    // Effective address from the fetched pointer, with optional indexing.
    always @* begin
        if (mode == `BMME_M_INDEXED) begin
            eff = ptr_idx;
        end else begin
            eff = MEM_RDATA_I;
        end
    end

    // Operand word and the results of both arithmetic paths.
    reg  [15:0] operand;
    reg  [15:0] sum;
    reg  [15:0] diff;
    reg         add_ovf;
    reg         sub_ovf;

    // Operand forming and full-width arithmetic.
    always @* begin
        if (byte_mode) begin
            if (byte_sel) begin
                operand = {8'h00, MEM_RDATA_I[7:0]};
            end else begin
                operand = {8'h00, MEM_RDATA_I[15:8]};
            end
        end else begin
            operand = MEM_RDATA_I;
        end
        // Both are full words, so a carry out of bit 7 runs on into bit 8.
        sum     = accum + operand;
        diff    = accum - operand;
        // Only a sign overflow of the whole word counts.
        add_ovf = (accum[15] == operand[15]) && (sum[15] != accum[15]);
        sub_ovf = (accum[15] != operand[15]) && (diff[15] != accum[15]);
    end

    // Sequencer: decode, optional pointer fetch, operand fetch and write-back.
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            // Reset clears every output and the captured context.
            state               <= S_IDLE;
            instr               <= `BMME_RST_WORD;
            prog_cnt            <= `BMME_RST_WORD;
            accum               <= `BMME_RST_WORD;
            index               <= `BMME_RST_WORD;
            byte_mode           <= 1'b0;
            byte_sel            <= 1'b0;
            cycles              <= `BMME_RST_CYC;
            BUSY_O              <= 1'b0;
            DONE_O              <= 1'b0;
            BAD_OPCODE_O        <= 1'b0;
            MEM_RD_O            <= 1'b0;
            MEM_ADDR_O          <= `BMME_RST_WORD;
            ACCUM_O             <= `BMME_RST_WORD;
            ACCUM_WE_O          <= 1'b0;
            INDEX_O             <= `BMME_RST_WORD;
            INDEX_WE_O          <= 1'b0;
            OVERFLOW_FLAG_SET_O <= 1'b0;
            EXEC_CYCLES_O       <= `BMME_RST_CYC;
        end else begin
            // Pulses last one cycle unless set again below.
            DONE_O              <= 1'b0;
            BAD_OPCODE_O        <= 1'b0;
            MEM_RD_O            <= 1'b0;
            ACCUM_WE_O          <= 1'b0;
            INDEX_WE_O          <= 1'b0;
            OVERFLOW_FLAG_SET_O <= 1'b0;
            case (state)
                S_IDLE: begin
                    // Wait for a request; only a free unit takes one.
                    if (START_I && start_ok) begin
                        // Capture the instruction and register context.
                        instr     <= INSTR_I;
                        prog_cnt  <= PROG_CNT_I;
                        accum     <= ACCUM_I;
                        index     <= INDEX_I;
                        byte_mode <= BYTE_MODE_I;
                        cycles    <= 2'h1;
                        BUSY_O    <= 1'b1;
                        state     <= S_DECODE;
                    end else if (START_I) begin
                        // Opcodes outside this unit finish at once, untouched.
                        DONE_O       <= 1'b1;
                        BAD_OPCODE_O <= 1'b1;
                    end
                end
                S_DECODE: begin
                    // Issue the first read: pointer location or operand word.
                    MEM_RD_O   <= 1'b1;
                    MEM_ADDR_O <= next_addr;
                    byte_sel   <= next_sel;
                    cycles     <= cycles + 2'h1;
                    // An indirect op spends one more cycle on the pointer.
                    if (indirect) begin
                        state <= S_PTR;
                    end else begin
                        state <= S_OPND;
                    end
                end
                S_PTR: begin
                    // In byte mode pointer content is a byte address; no second level follows.
                    MEM_RD_O <= 1'b1;
                    cycles   <= cycles + 2'h1;
                    // A byte pointer names its word by the pointer halved.
                    if (byte_mode) begin
                        MEM_ADDR_O <= {1'b0, eff[15:1]};
                        byte_sel   <= eff[0];
                    end else begin
                        // Word mode uses the pointer as a word address.
                        MEM_ADDR_O <= eff;
                    end
                    state <= S_OPND;
                end
                S_OPND: begin
                    // Write back the result of the selected operation.
                    case (opc)
                        `BMME_OPC_ADD: begin
                            // Full-word add of the operand, zero-extended in byte mode.
                            ACCUM_O             <= sum;
                            ACCUM_WE_O          <= 1'b1;
                            OVERFLOW_FLAG_SET_O <= add_ovf;
                        end
                        `BMME_OPC_SUB: begin
                            // Full-word subtract of the operand, zero-extended in byte mode.
                            ACCUM_O             <= diff;
                            ACCUM_WE_O          <= 1'b1;
                            OVERFLOW_FLAG_SET_O <= sub_ovf;
                        end
                        `BMME_OPC_LDA: begin
                            // Operand replaces the accumulator; no flag.
                            ACCUM_O    <= operand;
                            ACCUM_WE_O <= 1'b1;
                        end
                        `BMME_OPC_LDX: begin
                            // Operand replaces the index register; no flag.
                            INDEX_O    <= operand;
                            INDEX_WE_O <= 1'b1;
                        end
                        default: begin
                            ACCUM_WE_O <= 1'b0;
                        end
                    endcase
                    // The running count already holds the extra pointer cycle.
                    EXEC_CYCLES_O <= cycles;
                    DONE_O <= 1'b1;
                    BUSY_O <= 1'b0;
                    state  <= S_IDLE;
                end
                default: begin
                    // An illegal state code falls back to idle.
                    BUSY_O <= 1'b0;
                    state  <= S_IDLE;
                end
            endcase
        end
    end

endmodule // bmme_exec

// ### tb/bmme_exec_assertions.sv
// Purpose: Port checks for the execution block.
// Assumes: Bound to every instance of the block.
// Notes:   Opcode and operand size of the accepted op are tracked here.
`timescale 1ns/100ps
`include "bmme_defs.vh"

module bmme_exec_assertions (
    input logic        CLK_SYS_I, RST_I, START_I, BYTE_MODE_I, BUSY_O, DONE_O,
    input logic        BAD_OPCODE_O, MEM_RD_O, ACCUM_WE_O, INDEX_WE_O, OVERFLOW_FLAG_SET_O,
    input logic [15:0] INSTR_I, ACCUM_O, INDEX_O,
    input logic [1:0]  EXEC_CYCLES_O
);
    logic [4:0] opc_q;
    logic       bm_q;
    wire        take  = START_I && !BUSY_O;
    wire        legal = INSTR_I[15:11] inside {`BMME_OPC_ADD, `BMME_OPC_SUB,
                                               `BMME_OPC_LDA, `BMME_OPC_LDX};
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    // Tracks the opcode and operand size of the accepted instruction.
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            opc_q <= 5'h00;
            bm_q  <= 1'b0;
        end else if (take) begin
            opc_q <= INSTR_I[15:11];
            bm_q  <= BYTE_MODE_I;
        end
    end

    property p_direct;
        take && legal && !INSTR_I[8] |=> BUSY_O ##1 MEM_RD_O ##1 DONE_O && !BUSY_O;
    endproperty
    a_direct: assert property (p_direct) else $error("direct op timing wrong");
    property p_indir;
        take && legal && INSTR_I[8] |=> !MEM_RD_O ##1 MEM_RD_O [*2] ##1 DONE_O && !MEM_RD_O;
    endproperty
    a_indir: assert property (p_indir) else $error("indirect op wrong");
    property p_bad;
        take && !legal |=> DONE_O && BAD_OPCODE_O && !MEM_RD_O;
    endproperty
    a_bad: assert property (p_bad) else $error("bad opcode not refused");
    property p_rd_busy;
        MEM_RD_O |-> BUSY_O && !DONE_O;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read outside op");
    property p_cycles;
        DONE_O && !BAD_OPCODE_O |-> EXEC_CYCLES_O ==
            ($past(MEM_RD_O, 2) ? `BMME_CYC_INDIRECT : `BMME_CYC_DIRECT);
    endproperty
    a_cycles: assert property (p_cycles) else $error("cycle count wrong");
    property p_we;
        ACCUM_WE_O || INDEX_WE_O |-> DONE_O && (ACCUM_WE_O != INDEX_WE_O)
            && (INDEX_WE_O == (opc_q == `BMME_OPC_LDX));
    endproperty
    a_we: assert property (p_we) else $error("wrong write strobe");
    property p_ovf;
        OVERFLOW_FLAG_SET_O |-> ACCUM_WE_O && opc_q inside {`BMME_OPC_ADD, `BMME_OPC_SUB};
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow on wrong op");
    property p_lda;
        ACCUM_WE_O && bm_q && opc_q == `BMME_OPC_LDA |-> ACCUM_O[15:8] == 8'h00;
    endproperty
    a_lda: assert property (p_lda) else $error("accum upper byte set");
    property p_ldx;
        INDEX_WE_O && bm_q |-> INDEX_O[15:8] == 8'h00;
    endproperty
    a_ldx: assert property (p_ldx) else $error("index upper byte set");
    c_indir: cover property (take && legal && INSTR_I[8]);
    c_ovf: cover property (OVERFLOW_FLAG_SET_O);
    c_bad: cover property (BAD_OPCODE_O);
endmodule // bmme_exec_assertions

bind bmme_exec bmme_exec_assertions u_chk (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .START_I(START_I), .BYTE_MODE_I(BYTE_MODE_I),
    .BUSY_O(BUSY_O), .DONE_O(DONE_O), .BAD_OPCODE_O(BAD_OPCODE_O), .MEM_RD_O(MEM_RD_O),
    .ACCUM_WE_O(ACCUM_WE_O), .INDEX_WE_O(INDEX_WE_O), .INSTR_I(INSTR_I),
    .OVERFLOW_FLAG_SET_O(OVERFLOW_FLAG_SET_O), .ACCUM_O(ACCUM_O), .INDEX_O(INDEX_O),
    .EXEC_CYCLES_O(EXEC_CYCLES_O));

// ### tb/bmme_exec_test.sv
// Purpose: Self-checking bench for the execution block.
// Assumes: Memory model answers reads in the same cycle.
// Notes:   The driver notes expected results; a monitor compares them.
`timescale 1ns/100ps
`include "bmme_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module bmme_exec_test;
    logic        CLK_SYS_I = 1'b0, RST_I = 1'b1, START_I = 1'b0, BYTE_MODE_I = 1'b0;
    logic [15:0] INSTR_I = 16'h0000, PROG_CNT_I = 16'h0000, ACCUM_I = 16'h0000;
    logic [15:0] INDEX_I = 16'h0000, a_exp, k;
    wire  [15:0] MEM_RDATA_I, MEM_ADDR_O, ACCUM_O, INDEX_O;
    wire         BUSY_O, DONE_O, BAD_OPCODE_O, MEM_RD_O, ACCUM_WE_O, INDEX_WE_O, OVF_O;
    wire  [1:0]  EXEC_CYCLES_O;
    int          bad_count = 0, cmp_count = 0;
    logic [31:0] seed = 32'h0000_EBAB;
    logic [21:0] res_q[$], got, r_exp;
    logic [15:0] adr_q[$];
    logic [4:0]  opc_tab[4] = '{`BMME_OPC_ADD, `BMME_OPC_SUB, `BMME_OPC_LDA, `BMME_OPC_LDX};

    bmme_exec dut (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .START_I(START_I), .INSTR_I(INSTR_I),
        .BYTE_MODE_I(BYTE_MODE_I), .PROG_CNT_I(PROG_CNT_I), .ACCUM_I(ACCUM_I), .INDEX_I(INDEX_I),
        .MEM_RDATA_I(MEM_RDATA_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .BAD_OPCODE_O(BAD_OPCODE_O),
        .MEM_RD_O(MEM_RD_O), .MEM_ADDR_O(MEM_ADDR_O), .ACCUM_O(ACCUM_O), .ACCUM_WE_O(ACCUM_WE_O),
        .INDEX_O(INDEX_O), .INDEX_WE_O(INDEX_WE_O), .OVERFLOW_FLAG_SET_O(OVF_O),
        .EXEC_CYCLES_O(EXEC_CYCLES_O));
    bmme_mem_model u_mem (.clk_i(CLK_SYS_I), .rd_i(MEM_RD_O), .addr_i(MEM_ADDR_O),
        .rdata_o(MEM_RDATA_I));

    // Clock at 100 MHz.
    always #5 CLK_SYS_I = ~CLK_SYS_I;

    function automatic logic [15:0] lfsr_rnd();
        seed = {seed[30:0], ^(seed & 32'h8020_0003)};
        return seed[15:0];
    endfunction

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Notes the expected reads and result, then starts one op; rf adds a second start while the op is busy, which must be ignored.
    task automatic issue(input logic [15:0] ins, input logic bm, input logic [15:0] acc,
                         input logic rf);
        logic [15:0] d, pc, x, pa, ea, wa, w, op, r;
        logic        ind, sel, ovf, bad, ldx;
        logic [1:0]  m;
        m   = ins[10:9];
        ind = ins[8];
        d   = {8'h00, ins[7:0]};
        pc  = lfsr_rnd();
        x   = lfsr_rnd();
        ldx = ins[15:11] == `BMME_OPC_LDX;
        bad = !(ins[15:11] inside {`BMME_OPC_ADD, `BMME_OPC_SUB, `BMME_OPC_LDA, `BMME_OPC_LDX});
        pa  = (m == 2'h1) ? pc + 16'h0001 + d : (m == 2'h3) ? pc - d : d;
        if (ind) ea = u_mem.word_at(pa) + ((m == 2'h2) ? x : 16'h0000);
        else ea = (m == 2'h2) ? d + x : (bm && m == 2'h3) ? pc + 16'h0001 + d : pa;
        sel = (!ind && m[0]) ? m[1] : ea[0];
        wa  = (!bm || (!ind && m[0])) ? ea : {1'b0, ea[15:1]};
        w   = u_mem.word_at(wa);
        op  = !bm ? w : sel ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
        r   = (ins[15:11] == `BMME_OPC_ADD) ? acc + op :
              (ins[15:11] == `BMME_OPC_SUB) ? acc - op : op;
        ovf = (ins[15:11] == `BMME_OPC_ADD) ? acc[15] == op[15] && r[15] != acc[15] :
              (ins[15:11] == `BMME_OPC_SUB) && acc[15] != op[15] && r[15] != acc[15];
        if (bad) res_q.push_back(22'h20_0000);
        else res_q.push_back({1'b0, !ldx, ldx, ovf,
                              ind ? `BMME_CYC_INDIRECT : `BMME_CYC_DIRECT, r});
        if (!bad && ind) adr_q.push_back(pa);
        if (!bad) adr_q.push_back(wa);
        START_I     <= 1'b1;
        INSTR_I     <= ins;
        BYTE_MODE_I <= bm;
        PROG_CNT_I  <= pc;
        ACCUM_I     <= acc;
        INDEX_I     <= x;
        @(posedge CLK_SYS_I);
        START_I <= rf;
        INSTR_I <= lfsr_rnd();
        ACCUM_I <= lfsr_rnd();
        @(posedge CLK_SYS_I);
        START_I <= 1'b0;
        repeat (bad ? 1 : (ind ? 2 : 1)) @(posedge CLK_SYS_I);
    endtask

    // Compares each read address and each finished result with the oldest note.
    always @(negedge CLK_SYS_I) begin
        if (!RST_I && MEM_RD_O === 1'b1) begin
            a_exp = adr_q.size() ? adr_q.pop_front() : ~MEM_ADDR_O;
            `CHK(MEM_ADDR_O, a_exp)
        end
        if (!RST_I && DONE_O === 1'b1) begin
            got = {BAD_OPCODE_O, ACCUM_WE_O, INDEX_WE_O, OVF_O,
                   BAD_OPCODE_O ? 2'h0 : EXEC_CYCLES_O,
                   ACCUM_WE_O ? ACCUM_O : INDEX_WE_O ? INDEX_O : 16'h0000};
            r_exp = res_q.size() ? res_q.pop_front() : ~got;
            `CHK(got, r_exp)
        end
    end

    // Main sequence: every opcode, mode and size, random ops, then edge cases.
    initial begin
        repeat (3) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        // Every output must read zero while the unit sits idle after reset.
        @(negedge CLK_SYS_I);
        `CHK({BUSY_O, DONE_O, BAD_OPCODE_O, MEM_RD_O, ACCUM_WE_O, INDEX_WE_O, OVF_O}, '0)
        `CHK({EXEC_CYCLES_O, ACCUM_O, INDEX_O, MEM_ADDR_O}, '0)
        @(posedge CLK_SYS_I);
        for (int i = 0; i < 64; i++) begin
            k = lfsr_rnd();
            issue({opc_tab[i[5:4]], i[3:1], k[7:0]}, i[0], lfsr_rnd(), i[0] & i[2]);
        end
        repeat (60) begin
            k = lfsr_rnd();
            issue({opc_tab[k[1:0]], k[4:2], k[15:8]}, k[5], lfsr_rnd(), 1'b0);
        end
        issue(16'h8800, 1'b1, 16'h7FF0, 1'b0);
        issue(16'h8800, 1'b1, 16'h00F0, 1'b0);
        issue(16'h9000, 1'b1, 16'h8000, 1'b0);
        issue(16'h0000, 1'b1, 16'h1234, 1'b0);
        repeat (4) @(posedge CLK_SYS_I);
        `CHK(res_q.size() + adr_q.size(), 0)
        print_verdict();
    end

    // Watchdog cuts a hang short.
    initial begin
        repeat (5000) @(posedge CLK_SYS_I);
        bad_count++;
        print_verdict();
    end
endmodule // bmme_exec_test

// ### tb/bmme_mem_model.sv
// Purpose: Word memory model on the far side of the execution block.
// Assumes: Read data is combinational while the read strobe is high.
// Notes:   Contents are a fixed function of the address.
`timescale 1ns/100ps

module bmme_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] last = 16'h0000;

    // Neighbouring words differ, so a wrong address shows in the data.
    function automatic logic [15:0] word_at(input logic [15:0] a);
        return {a[7:0] ^ 8'h96, a[15:8] + 8'h3C};
    endfunction

    // Remembers the last word read.
    always @(posedge clk_i) begin
        if (rd_i) begin
            last <= rdata_o;
        end
    end

    // Outside a read the bus shows the inverse of the last word, never a stale copy.
    assign rdata_o = rd_i ? word_at(addr_i) : ~last;
endmodule // bmme_mem_model
